// ==== hdl/source_bit_mux.v ====
// One source selector: code to single command bit
`include "start_stop_consts.vh"
module source_bit_mux (
  input  wire [5:0]  i_select,   // Selector code
  input  wire [3:0]  i_din,      // Debounced digital inputs
  input  wire [1:0]  i_bidir,    // Bidirectional pin inputs
  input  wire [2:0]  i_timed,    // Timed-function status
  input  wire [5:0]  i_superv,   // Supervision status
  input  wire        i_pointer,  // Bit chosen by pointer
  output reg         o_bit       // Selected bit
);
  // Decode selector code to a source bit; unknown codes give zero
  always @* begin
    o_bit = 1'b0;
    if (i_select == `SEL_CONST_ONE) begin
      o_bit = 1'b1;
    end else if (i_select >= `SEL_DIGITAL_IN1 && i_select <= `SEL_DIGITAL_IN4) begin
      o_bit = i_din[i_select[1:0] - 2'd2];
    end else if (i_select == `SEL_BIDIR_ONE || i_select == `SEL_BIDIR_TWO) begin
      o_bit = i_bidir[i_select[0]];
    end else if (i_select >= `SEL_TIMED_ONE && i_select <= `SEL_TIMED_THREE) begin
      o_bit = i_timed[i_select[1:0] - 2'd2];
    end else if (i_select >= `SEL_SUPERV_ONE && i_select <= `SEL_SUPERV_SIX) begin
      // Codes 0x15..0x1A wrap modulo 8 onto bits 0..5
      o_bit = i_superv[i_select[2:0] - 3'd5];
    end else if (i_select == `SEL_POINTER) begin
      o_bit = i_pointer;
    end
  end
endmodule

// ==== hdl/start_stop_consts.vh ====
// Constants for the start/stop source decoder
`ifndef START_STOP_CONSTS_VH
`define START_STOP_CONSTS_VH

// APB register offsets (byte addresses)
`define ADDR_LOC_A_SELECT   12'h0000
`define ADDR_LOC_B_CONFIG   12'h0004
`define ADDR_POINTER_SELECT 12'h0008
`define ADDR_STATUS         12'h000C

// Source selector codes
`define SEL_CONST_ZERO  6'h00
`define SEL_CONST_ONE   6'h01
`define SEL_DIGITAL_IN1 6'h02
`define SEL_DIGITAL_IN4 6'h05
`define SEL_BIDIR_ONE   6'h0A
`define SEL_BIDIR_TWO   6'h0B
`define SEL_TIMED_ONE   6'h12
`define SEL_TIMED_THREE 6'h14
`define SEL_SUPERV_ONE  6'h15
`define SEL_SUPERV_SIX  6'h1A
`define SEL_POINTER     6'h3F

// Location B command modes
`define MODE_NOT_SELECTED      2'h0
`define MODE_SINGLE_SOURCE_RUN 2'h1
`define MODE_RUN_WITH_DIR      2'h2
`define MODE_FWD_REV_RUN       2'h3

// Trigger type
`define TRIG_EDGE  1'b0
`define TRIG_LEVEL 1'b1

// Reset values
`define RST_LOC_A_ONE   6'h02
`define RST_LOC_A_TWO   6'h03
`define RST_LOC_A_THREE 6'h00
`define RST_LOC_B_MODE  2'h0
`define RST_LOC_B_TRIG  1'b1
`define RST_LOC_B_ONE   6'h02
`define RST_LOC_B_TWO   6'h03

`endif

// ==== hdl/start_stop_source_decoder.v ====
// Start/stop command decoder for external control locations
`include "start_stop_consts.vh"
module start_stop_source_decoder (
  input  wire        i_sys_clk,   // System clock, 100 MHz
  input  wire        i_reset,     // Synchronous reset, active high
  input  wire        i_ce,        // Clock enable, freezes state when low
  input  wire        psel,        // APB select
  input  wire        penable,     // APB enable
  input  wire        pwrite,      // APB write
  input  wire [11:0] paddr,       // APB address
  input  wire [31:0] pwdata,      // APB write data
  output wire        pready,      // APB ready
  output wire        pslverr,     // APB error
  output reg  [31:0] prdata,      // APB read data
  input  wire [3:0]  i_din,       // Debounced digital inputs
  input  wire [1:0]  i_bidir,     // Bidirectional pin inputs
  input  wire [2:0]  i_timed,     // Timed-function status
  input  wire [5:0]  i_superv,    // Supervision status
  input  wire [31:0] i_bit_pool,  // Word for pointer choice
  output wire        o_loc_a_src_one,   // Location A source one bit
  output wire        o_loc_a_src_two,   // Location A source two bit
  output wire        o_loc_a_src_three, // Location A source three bit
  output reg         o_start,     // Start command, level; one-cycle pulse with edge trigger
  output reg         o_stop,      // Stop command, level
  output reg         o_reverse    // Direction of start, 1 reverse
);
  reg  [5:0] loc_a_source_one_select;
  reg  [5:0] loc_a_source_two_select;
  reg  [5:0] loc_a_source_three_select;
  reg  [5:0] loc_b_source_one_select;
  reg  [5:0] loc_b_source_two_select;
  reg  [1:0] loc_b_command_mode;
  reg        loc_b_trigger;
  reg  [4:0] pointer_index;
  reg        prev_one;
  reg        prev_two;
  reg        next_start;
  reg        next_stop;
  reg        next_reverse;
  wire [4:0] sel_bits;
  wire       src_one;
  wire       src_two;
  wire       rise_one;
  wire       rise_two;
  wire       wr_en;
  wire       mapped;

  // Five muxes share one module; pointer bit picked from the pool
  wire       pointer_bit = i_bit_pool[pointer_index];
  wire [29:0] sel_codes = {loc_a_source_one_select, loc_a_source_two_select,
                           loc_a_source_three_select, loc_b_source_one_select,
                           loc_b_source_two_select};
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_mux
      source_bit_mux u_mux (
        .i_select  (sel_codes[6*g+5:6*g]),
        .i_din     (i_din),
        .i_bidir   (i_bidir),
        .i_timed   (i_timed),
        .i_superv  (i_superv),
        .i_pointer (pointer_bit),
        .o_bit     (sel_bits[g])
      );
    end
  endgenerate
  assign src_two           = sel_bits[0];
  assign src_one           = sel_bits[1];
  assign o_loc_a_src_three = sel_bits[2];
  assign o_loc_a_src_two   = sel_bits[3];
  assign o_loc_a_src_one   = sel_bits[4];

  // APB: zero wait states, unmapped addresses flag an error
  assign pready  = 1'b1;
  assign mapped  = (paddr == `ADDR_LOC_A_SELECT) || (paddr == `ADDR_LOC_B_CONFIG) ||
                   (paddr == `ADDR_POINTER_SELECT) || (paddr == `ADDR_STATUS);
  assign pslverr = psel & penable & ~mapped;
  assign wr_en   = psel & penable & pwrite & mapped & i_ce;

  // Configuration registers written by software
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      loc_a_source_one_select   <= `RST_LOC_A_ONE;
      loc_a_source_two_select   <= `RST_LOC_A_TWO;
      loc_a_source_three_select <= `RST_LOC_A_THREE;
      loc_b_command_mode        <= `RST_LOC_B_MODE;
      loc_b_trigger             <= `RST_LOC_B_TRIG;
      loc_b_source_one_select   <= `RST_LOC_B_ONE;
      loc_b_source_two_select   <= `RST_LOC_B_TWO;
      pointer_index             <= 5'h00;
    end else if (wr_en) begin
      case (paddr)
        `ADDR_LOC_A_SELECT: begin
          loc_a_source_one_select   <= pwdata[5:0];
          loc_a_source_two_select   <= pwdata[13:8];
          loc_a_source_three_select <= pwdata[21:16];
        end
        `ADDR_LOC_B_CONFIG: begin
          loc_b_command_mode      <= pwdata[1:0];
          loc_b_trigger           <= pwdata[2];
          loc_b_source_one_select <= pwdata[13:8];
          loc_b_source_two_select <= pwdata[21:16];
        end
        `ADDR_POINTER_SELECT: begin
          pointer_index <= pwdata[4:0];
        end
        default: begin
          pointer_index <= pointer_index;
        end
      endcase
    end
  end

  // Read mux; status word shows live commands and source bits
  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `ADDR_LOC_A_SELECT:   prdata = {10'h000, loc_a_source_three_select, 2'b00,
                                      loc_a_source_two_select, 2'b00, loc_a_source_one_select};
      `ADDR_LOC_B_CONFIG:   prdata = {10'h000, loc_b_source_two_select, 2'b00,
                                      loc_b_source_one_select, 5'h00, loc_b_trigger,
                                      loc_b_command_mode};
      `ADDR_POINTER_SELECT: prdata = {27'h000_0000, pointer_index};
      `ADDR_STATUS:         prdata = {27'h000_0000, src_two, src_one,
                                      o_reverse, o_stop, o_start};
      default:              prdata = 32'h0000_0000;
    endcase
  end

  assign rise_one = src_one & ~prev_one;
  assign rise_two = src_two & ~prev_two;

  // Command decode per location B mode
  always @* begin
    next_start   = 1'b0;
    next_stop    = 1'b0;
    next_reverse = o_reverse;
    case (loc_b_command_mode)
      `MODE_NOT_SELECTED: begin
        next_start = 1'b0;
      end
      `MODE_SINGLE_SOURCE_RUN: begin
        next_stop  = ~src_one;
        next_start = (loc_b_trigger == `TRIG_LEVEL) ? src_one : rise_one;
      end
      `MODE_RUN_WITH_DIR: begin
        next_stop  = ~src_one;
        next_start = (loc_b_trigger == `TRIG_LEVEL) ? src_one : rise_one;
        if (next_start) begin
          next_reverse = src_two;
        end
      end
      `MODE_FWD_REV_RUN: begin
        if (src_one == src_two) begin
          next_stop = ~src_one | src_two;
        end else if (src_one) begin
          next_start   = (loc_b_trigger == `TRIG_LEVEL) ? 1'b1 : rise_one;
          next_reverse = 1'b0;
        end else begin
          next_start   = (loc_b_trigger == `TRIG_LEVEL) ? 1'b1 : rise_two;
          next_reverse = 1'b1;
        end
      end
      default: begin
        next_start = 1'b0;
      end
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      prev_one  <= 1'b0;
      prev_two  <= 1'b0;
      o_start   <= 1'b0;
      o_stop    <= 1'b0;
      o_reverse <= 1'b0;
    end else if (i_ce) begin
      prev_one  <= src_one;
      prev_two  <= src_two;
      o_start   <= next_start;
      o_stop    <= next_stop;
      o_reverse <= next_reverse;
    end
  end
endmodule

// ==== verif/input_source_model.sv ====
// Far-side model: digital inputs and internal status bits
module input_source_model (
  input  wire logic        i_sys_clk, // Clock
  input  wire logic [46:0] i_scene,   // Levels asked by the bench
  output logic      [46:0] o_bits     // Levels seen by the block
);
  timeunit 1ns;
  timeprecision 1ns;
  // debounced levels only move on clock edges, so glitches between edges never reach the block
  initial o_bits = '0;
  always @(posedge i_sys_clk) begin
    o_bits <= i_scene;
  end
endmodule

// ==== verif/start_stop_source_decoder_checker.sv ====
// Assertion checker for the start/stop source decoder
module start_stop_source_decoder_checker (
  input wire logic        i_sys_clk,         // Clock
  input wire logic        i_reset,           // Reset
  input wire logic        i_ce,              // Enable
  input wire logic        psel,              // APB
  input wire logic        penable,           // APB
  input wire logic        pwrite,            // APB
  input wire logic [11:0] paddr,             // APB
  input wire logic [31:0] pwdata,            // APB
  input wire logic        pslverr,           // APB
  input wire logic [3:0]  i_din,             // Inputs
  input wire logic [2:0]  i_timed,           // Timed bits
  input wire logic [5:0]  i_superv,          // Supervision
  input wire logic        o_loc_a_src_one,   // Source
  input wire logic        o_loc_a_src_two,   // Source
  input wire logic        o_loc_a_src_three, // Source
  input wire logic        o_start,           // Start
  input wire logic        o_stop             // Stop
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] mode;
  logic       trig;
  logic [5:0] s1, s2, s3;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Shadow of the settings, snooped from bus writes; dropped writes stay dropped
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      mode <= 2'h0;
      trig <= 1'b1;
      s1 <= 6'h02;
      s2 <= 6'h03;
      s3 <= 6'h00;
    end else if (psel && penable && pwrite && i_ce && paddr == 12'h000) begin
      s1 <= pwdata[5:0];
      s2 <= pwdata[13:8];
      s3 <= pwdata[21:16];
    end else if (psel && penable && pwrite && i_ce && paddr == 12'h004) begin
      mode <= pwdata[1:0];
      trig <= pwdata[2];
    end
  end
  a_unmapped_error: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
    else $error("unmapped access without error");
  a_reset_quiet: assert property ($past(i_reset) |-> !o_start && !o_stop)
    else $error("command right after reset");
  a_mode_zero: assert property (i_ce && mode == 2'h0 |=> !o_start && !o_stop)
    else $error("command while not selected");
  a_timed_route: assert property (s1 inside {[6'd18:6'd20]} |->
    o_loc_a_src_one == i_timed[s1 - 6'd18]) else $error("timed bit misrouted");
  a_superv_route: assert property (s2 inside {[6'd21:6'd26]} |->
    o_loc_a_src_two == i_superv[s2 - 6'd21]) else $error("supervision bit misrouted");
  a_input_route: assert property (s1 inside {[6'd2:6'd5]} |->
    o_loc_a_src_one == i_din[s1 - 6'd2]) else $error("digital input misrouted");
  a_const_route: assert property (s3 <= 6'd1 |-> o_loc_a_src_three == s3[0])
    else $error("constant source wrong");
  a_no_clash: assert property (!(o_start && o_stop))
    else $error("start and stop together");
  a_edge_single: assert property (o_start && i_ce && mode == 2'h1 && !trig |=> !o_start)
    else $error("edge start longer than one cycle");
endmodule
bind start_stop_source_decoder start_stop_source_decoder_checker
  start_stop_source_decoder_checker_i (.i_sys_clk, .i_reset, .i_ce, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pslverr, .i_din, .i_timed, .i_superv, .o_loc_a_src_one, .o_loc_a_src_two,
  .o_loc_a_src_three, .o_start, .o_stop);

// ==== verif/start_stop_source_decoder_test.sv ====
// Self-checking bench for the start/stop source decoder
module start_stop_source_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_sys_clk = 0, i_reset = 1, psel = 0, penable = 0, pwrite = 0, e, ce = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic [46:0] scene = 0;
  wire  [46:0] bits;
  wire  [31:0] prdata;
  wire         pready, pslverr, o_loc_a_src_one, o_loc_a_src_two, o_loc_a_src_three;
  wire         o_start, o_stop, o_reverse;
  int          fails = 0, check_count = 0, n;
  logic [5:0]  codes [18] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h0A, 6'h0B, 6'h12,
                              6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h3F};
  logic [17:0] picks = 18'h3_356A;
  // Steps: mode, trigger, {source two, source one}, check direction, start, stop, reverse
  logic [8:0]  steps [10] = '{9'h070, 9'h0F4, 9'h0D4, 9'h0E2, 9'h17D, 9'h162, 9'h15C,
                              9'h1ED, 9'h1F2, 9'h1DC};
  input_source_model input_source_model_i (.i_sys_clk, .i_scene(scene), .o_bits(bits));
  start_stop_source_decoder start_stop_source_decoder_i (
    .i_sys_clk, .i_reset, .i_ce(ce), .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .i_din(bits[3:0]), .i_bidir(bits[5:4]), .i_timed(bits[8:6]),
    .i_superv(bits[14:9]), .i_bit_pool(bits[46:15]), .o_loc_a_src_one, .o_loc_a_src_two,
    .o_loc_a_src_three, .o_start, .o_stop, .o_reverse);
  // Free-running 100 MHz clock
  always #5 i_sys_clk = ~i_sys_clk;
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
    end
  endtask
  // One APB transfer; the wait on pready is bounded so a stuck slave ends the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge i_sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fails++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Main sequence: defaults, source routing, command modes, then edge timing
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_reset <= 0;
    apb(0, 12'h000, 0);
    check("loc a select", q, 32'h0000_0302);
    apb(0, 12'h004, 0);
    check("loc b config", q, 32'h0003_0204);
    apb(0, 12'h010, 0);
    check("unmapped", {e, q}, 33'h1_0000_0000);
    scene <= {32'h0000_0080, 6'h26, 3'h5, 2'h1, 4'hA};
    apb(1, 12'h008, 32'h0000_0007);
    for (int i = 0; i < 18; i++) begin
      apb(1, 12'h000, {10'h000, codes[i], 2'h0, codes[i], 2'h0, codes[i]});
      @(posedge i_sys_clk);
      #1;
      check("loc a bits", {o_loc_a_src_one, o_loc_a_src_two, o_loc_a_src_three},
            {3{picks[i]}});
    end
    foreach (steps[i]) begin
      apb(1, 12'h004, {10'h000, 6'h03, 2'h0, 6'h02, 5'h00, steps[i][6], steps[i][8:7]});
      scene[1:0] <= steps[i][5:4];
      repeat (4) @(posedge i_sys_clk);
      #1;
      check("start stop", {o_start, o_stop}, steps[i][2:1]);
      if (steps[i][3]) check("reverse", o_reverse, steps[i][0]);
    end
    apb(1, 12'h004, 32'h0003_0201);
    scene[1:0] <= 2'h0;
    repeat (4) @(posedge i_sys_clk);
    #1;
    check("edge idle", {o_start, o_stop}, 2'h1);
    @(posedge i_sys_clk);
    scene[1:0] <= 2'h1;
    for (n = 0; n < 6 && o_start !== 1'b1; n++) begin
      @(posedge i_sys_clk);
      #1;
    end
    check("edge delay", n, 2);
    @(posedge i_sys_clk);
    #1;
    check("edge pulse", {o_start, o_stop}, 2'h0);
    // Status word: source one high, source two low, no command, forward
    apb(0, 12'h00C, 0);
    check("status", q, 32'h0000_0008);
    // A write with the clock enable low must be dropped
    ce <= 0;
    apb(1, 12'h000, 32'h0000_0000);
    ce <= 1;
    apb(0, 12'h000, 0);
    check("frozen write", q, 32'h003F_3F3F);
    wrap_up();
  end
endmodule
